/* File: hdl/bae_top.sv */
// Beam area evaluation with AXI4-Lite register slave
`timescale 1ns/10ps
module bae_top #(
    parameter int BEAM_COUNT = 64,
    parameter int AREA_COUNT = bae_pkg::MAX_AREAS,
    parameter int OUT_COUNT = bae_pkg::MAX_OUTS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Beam states, one bit per beam, 1 = interrupted
    input wire logic [BEAM_COUNT-1:0] beam_interrupted,
    input wire logic beam_valid,
    // Local control panel teach
    input wire logic panel_teach_req,
    input wire logic [1:0] panel_teach_slot,
    // Area results, teach busy and interrupt
    output logic [bae_pkg::WORD_HALF-1:0] area_state_low_word,
    output logic [bae_pkg::WORD_HALF-1:0] area_state_high_word,
    output logic [OUT_COUNT-1:0] switch_out,
    output logic teach_busy,
    output logic irq,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [bae_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [bae_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import bae_pkg::*;

    if (BEAM_COUNT < 2 || BEAM_COUNT > MAX_BEAMS) begin
        $error("BEAM_COUNT out of range");
    end
    if (AREA_COUNT < HEIGHT_AREAS || AREA_COUNT > MAX_AREAS) begin
        $error("AREA_COUNT out of range");
    end
    if (OUT_COUNT < 1 || OUT_COUNT > MAX_OUTS) begin
        $error("OUT_COUNT out of range");
    end

    typedef struct packed {
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic auto_en;
        logic auto_or;
        logic [CNT_W-1:0] auto_cnt;
        logic hold_en;
        logic [BEAM_COUNT-1:0] held;
        logic [AREA_COUNT-1:0] area;
        logic [AREA_COUNT-1:0][BEAM_W-1:0] a_start;
        logic [AREA_COUNT-1:0][BEAM_W-1:0] a_end;
        logic [AREA_COUNT-1:0] a_or;
        logic [AREA_COUNT-1:0] a_en;
        logic [AREA_COUNT-1:0] a_taught;
        logic [OUT_COUNT-1:0][SEL_W-1:0] out_sel;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        bae_teach_type teach;
        logic [1:0] t_slot;
        logic t_panel;
        logic t_err;
    } bae_state_type;

    bae_state_type s_q;
    bae_state_type s_d;

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // One area reduced to a single bit over adjacent beams
    function automatic logic eval_area(input logic [BEAM_COUNT-1:0] b,
                                       input logic [BEAM_W-1:0] st, input logic [BEAM_W-1:0] en,
                                       input logic use_or);
        logic any_hit;
        logic all_hit;
        logic in_range;
        logic nonempty;
        any_hit = 1'b0;
        all_hit = 1'b1;
        nonempty = 1'b0;
        for (int i = 0; i < BEAM_COUNT; i++) begin
            in_range = (BEAM_W'(i) >= st) && (BEAM_W'(i) <= en);
            nonempty = nonempty | in_range;
            any_hit = any_hit | (in_range & b[i]);
            all_hit = all_hit & (~in_range | b[i]);
        end
        return use_or ? any_hit : (all_hit & nonempty);
    endfunction : eval_area

    logic [31:0] area_word;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [BEAM_W:0] split_size;
    logic [CNT_W-1:0] split_cnt;
    logic [AREA_COUNT-1:0] area_eval;
    logic [BEAM_COUNT-1:0] beams_now;
    logic [BEAM_W-1:0] hi_hit;
    logic [BEAM_W-1:0] lo_hit;
    logic [ADDR_W-1:0] ra;
    logic [4:0] ridx;

    always_comb begin
        area_word = '0;
        area_word[AREA_COUNT-1:0] = s_q.area;
    end

    // Held beam view: in hold mode an interrupted beam stays set until cleared
    logic hold_clr;
    always_comb begin
        hold_clr = s_q.aw_full && s_q.w_full && !s_q.bvalid && s_q.aw_addr == OFS_CMD
            && s_q.w_strb[0] && s_q.w_data[CMD_HOLD_CLR];
        if (!s_q.hold_en) begin
            beams_now = beam_interrupted;
        end else if (hold_clr) begin
            beams_now = beam_interrupted;
        end else begin
            beams_now = s_q.held | beam_interrupted;
        end
    end

    // Autosplit area geometry
    always_comb begin
        split_cnt = (s_q.auto_cnt == '0) ? CNT_W'(1) : s_q.auto_cnt;
        if (split_cnt > CNT_W'(AREA_COUNT)) begin
            split_cnt = CNT_W'(AREA_COUNT);
        end
        split_size = (BEAM_W+1)'(BEAM_COUNT) / (BEAM_W+1)'(split_cnt);
    end

    // Area evaluation, every area in parallel
    for (genvar a = 0; a < AREA_COUNT; a++) begin : g_area
        logic [15:0] as;
        logic [15:0] ae;
        always_comb begin
            as = 16'(a) * 16'(split_size);
            ae = as + 16'(split_size) - 16'h0001;
            if (s_q.auto_en) begin
                area_eval[a] = (CNT_W'(a) < split_cnt) && split_size != '0
                    && eval_area(beams_now, as[BEAM_W-1:0], ae[BEAM_W-1:0], s_q.auto_or);
            end else begin
                area_eval[a] = s_q.a_en[a] && eval_area(beams_now, s_q.a_start[a],
                    s_q.a_end[a], s_q.a_or[a] | s_q.a_taught[a]);
            end
        end
    end

    // Highest and lowest interrupted beam for the height teach
    always_comb begin
        hi_hit = '0;
        lo_hit = BEAM_W'(BEAM_COUNT - 1);
        for (int i = 0; i < BEAM_COUNT; i++) begin
            if (beams_now[i]) begin
                hi_hit = BEAM_W'(i);
            end
            if (beams_now[BEAM_COUNT-1-i]) begin
                lo_hit = BEAM_W'(BEAM_COUNT - 1 - i);
            end
        end
    end

    // Register read decode
    always_comb begin
        ra = s_axi_araddr;
        ridx = ra[6:2];
        rd_word = '0;
        rd_ok = 1'b1;
        if (ra[AREA_BASE_BIT] && ra[1:0] == 2'h0) begin
            if (32'(ridx) < AREA_COUNT) begin
                rd_word[ACF_START_LSB +: BEAM_W] = s_q.a_start[ridx];
                rd_word[ACF_END_LSB +: BEAM_W] = s_q.a_end[ridx];
                rd_word[ACF_OR] = s_q.a_or[ridx];
                rd_word[ACF_EN] = s_q.a_en[ridx];
                rd_word[ACF_TAUGHT] = s_q.a_taught[ridx];
            end else begin
                rd_ok = 1'b0;
            end
        end else begin
            case (ra)
                OFS_CTRL: begin
                    rd_word[CTRL_AUTO_EN] = s_q.auto_en;
                    rd_word[CTRL_AUTO_OR] = s_q.auto_or;
                    rd_word[CTRL_CNT_LSB +: CNT_W] = s_q.auto_cnt;
                    rd_word[CTRL_HOLD_EN] = s_q.hold_en;
                end
                OFS_CMD: rd_word = '0;
                OFS_STATUS: begin
                    rd_word[STS_BUSY] = (s_q.teach == BAE_TEACH_ARMED);
                    rd_word[STS_ERR] = s_q.t_err;
                    rd_word[STS_TAUGHT_LSB +: HEIGHT_AREAS] = s_q.a_taught[HEIGHT_AREAS-1:0];
                end
                OFS_AREA_LOW: rd_word[WORD_HALF-1:0] = area_word[WORD_HALF-1:0];
                OFS_AREA_HIGH: rd_word[WORD_HALF-1:0] = area_word[31:WORD_HALF];
                OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = s_q.irq_stat;
                OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = s_q.irq_mask;
                OFS_OUT_SEL: begin
                    for (int o = 0; o < OUT_COUNT; o++) begin
                        rd_word[o*SEL_STRIDE +: SEL_W] = s_q.out_sel[o];
                    end
                end
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // Next state
    logic [31:0] wm;
    logic [4:0] widx;
    logic do_write;
    logic [IRQ_W-1:0] events;
    logic teach_go;
    logic teach_host;
    logic [1:0] teach_slot_in;
    always_comb begin
        s_d = s_q;
        events = '0;
        wm = '0;
        widx = s_q.aw_addr[6:2];
        teach_go = 1'b0;
        teach_host = 1'b0;
        teach_slot_in = panel_teach_slot;
        // Write channel capture, address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
        if (do_write) begin
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (s_q.aw_addr[AREA_BASE_BIT] && s_q.aw_addr[1:0] == 2'h0) begin
                if (32'(widx) < AREA_COUNT) begin
                    wm = merge(32'({s_q.a_en[widx], s_q.a_or[widx], s_q.a_end[widx],
                        s_q.a_start[widx]}), s_q.w_data, s_q.w_strb);
                    s_d.a_start[widx] = wm[ACF_START_LSB +: BEAM_W];
                    s_d.a_end[widx] = wm[ACF_END_LSB +: BEAM_W];
                    s_d.a_or[widx] = wm[ACF_OR];
                    s_d.a_en[widx] = wm[ACF_EN];
                    s_d.a_taught[widx] = 1'b0;
                end else begin
                    s_d.bresp = RESP_SLVERR;
                end
            end else begin
                case (s_q.aw_addr)
                    OFS_CTRL: begin
                        wm = merge({15'h0000, s_q.hold_en, 2'h0, s_q.auto_cnt, 6'h00,
                            s_q.auto_or, s_q.auto_en}, s_q.w_data, s_q.w_strb);
                        s_d.auto_en = wm[CTRL_AUTO_EN];
                        s_d.auto_or = wm[CTRL_AUTO_OR];
                        s_d.auto_cnt = wm[CTRL_CNT_LSB +: CNT_W];
                        s_d.hold_en = wm[CTRL_HOLD_EN];
                    end
                    OFS_CMD: begin
                        if (s_q.w_strb[0] && s_q.w_data[CMD_TEACH]) begin
                            teach_host = 1'b1;
                            teach_slot_in = s_q.w_data[CMD_SLOT_LSB +: 2];
                        end
                    end
                    OFS_IRQ_STAT: begin
                        wm = merge('0, s_q.w_data, s_q.w_strb);
                        s_d.irq_stat = s_q.irq_stat & ~wm[IRQ_W-1:0];
                    end
                    OFS_IRQ_MASK: begin
                        wm = merge(32'(s_q.irq_mask), s_q.w_data, s_q.w_strb);
                        s_d.irq_mask = wm[IRQ_W-1:0];
                    end
                    OFS_OUT_SEL: begin
                        wm = merge('0, s_q.w_data, s_q.w_strb);
                        for (int o = 0; o < OUT_COUNT; o++) begin
                            if (s_q.w_strb[o]) begin
                                s_d.out_sel[o] = wm[o*SEL_STRIDE +: SEL_W];
                            end
                        end
                    end
                    OFS_STATUS, OFS_AREA_LOW, OFS_AREA_HIGH: s_d.bresp = RESP_OKAY;
                    default: s_d.bresp = RESP_SLVERR;
                endcase
            end
        end
        // Read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        // Measurement cycle: hold state and area bits
        if (beam_valid) begin
            s_d.held = s_q.hold_en ? beams_now : '0;
            s_d.area = area_eval;
            if (area_eval != s_q.area) begin
                events[EV_CHANGE] = 1'b1;
            end
        end else if (hold_clr) begin
            s_d.held = '0;
        end
        // Height teach
        case (s_q.teach)
            BAE_TEACH_IDLE: begin
                teach_go = teach_host || panel_teach_req;
                if (teach_go) begin
                    s_d.teach = BAE_TEACH_ARMED;
                    s_d.t_slot = teach_slot_in;
                    s_d.t_panel = !teach_host;
                end
            end
            BAE_TEACH_ARMED: begin
                if (beam_valid) begin
                    s_d.teach = BAE_TEACH_IDLE;
                    s_d.t_err = 1'b0;
                    if (beams_now == '0) begin
                        s_d.a_start[s_q.t_slot] = '0;
                        s_d.a_end[s_q.t_slot] = BEAM_W'(BEAM_COUNT - 1);
                    end else if (!s_q.t_panel) begin
                        s_d.t_err = 1'b1;
                    end else if (beams_now[0] && !beams_now[BEAM_COUNT-1]) begin
                        s_d.a_start[s_q.t_slot] = hi_hit + BEAM_W'(1);
                        s_d.a_end[s_q.t_slot] = BEAM_W'(BEAM_COUNT - 1);
                    end else if (beams_now[BEAM_COUNT-1] && !beams_now[0]) begin
                        s_d.a_start[s_q.t_slot] = '0;
                        s_d.a_end[s_q.t_slot] = lo_hit - BEAM_W'(1);
                    end else begin
                        s_d.t_err = 1'b1;
                    end
                    if (s_d.t_err) begin
                        events[EV_TEACH_ERR] = 1'b1;
                    end else begin
                        events[EV_TEACH_DONE] = 1'b1;
                        s_d.a_en[s_q.t_slot] = 1'b1;
                        s_d.a_or[s_q.t_slot] = 1'b1;
                        s_d.a_taught[s_q.t_slot] = 1'b1;
                        if (s_q.t_panel && 32'(s_q.t_slot) < OUT_COUNT) begin
                            s_d.out_sel[s_q.t_slot] = SEL_W'(s_q.t_slot);
                        end
                    end
                end
            end
            default: s_d.teach = BAE_TEACH_IDLE;
        endcase
        // Sticky events: a new event wins over a same-cycle clear
        s_d.irq_stat = s_d.irq_stat | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.auto_cnt <= RST_AUTO_CNT;
            s_q.teach <= BAE_TEACH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign s_axi_awready = !s_q.aw_full && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_full && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign area_state_low_word = area_word[WORD_HALF-1:0];
    assign area_state_high_word = area_word[31:WORD_HALF];
    assign teach_busy = (s_q.teach == BAE_TEACH_ARMED);
    assign irq = |(s_q.irq_stat & s_q.irq_mask);

    for (genvar o = 0; o < OUT_COUNT; o++) begin : g_out
        assign switch_out[o] = area_word[s_q.out_sel[o]];
    end
endmodule : bae_top

/* File: pkg/bae_pkg.sv */
// Constants, register map and types for the beam area evaluation block
// What this block does
// - Beams map onto up to 32 areas.
// - Each area reduces to one state bit.
// - Area spans adjacent beams, start to end.
// - AND area is 1 only if all interrupted.
// - OR area is 1 if any interrupted.
// - Areas may abut or overlap freely.
// - Autosplit divides beams into equal areas.
// - Area bits readable as high and low word.
// - Area bits follow held beam states.
// - Any area can drive a switching output.
// - Teach supports at most four height areas.
// - Teach joins free beams above/below object.
// - Teach with all beams free spans everything.
// - Taught height areas always use OR.
// - Panel teach assigns outputs to height areas.
// - Host teach with object present reports error.
package bae_pkg;
    localparam int ADDR_W = 8;
    localparam int BEAM_W = 8;
    localparam int MAX_AREAS = 32;
    localparam int MAX_BEAMS = 256;
    localparam int HEIGHT_AREAS = 4;
    localparam int MAX_OUTS = 4;
    localparam int WORD_HALF = 16;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_AREA_LOW = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_AREA_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_OUT_SEL = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_AREA_BASE = 8'h80;
    localparam int AREA_BASE_BIT = 7;
    // CTRL fields
    localparam int CTRL_AUTO_EN = 0;
    localparam int CTRL_AUTO_OR = 1;
    localparam int CTRL_CNT_LSB = 8;
    localparam int CNT_W = 6;
    localparam int CTRL_HOLD_EN = 16;
    localparam logic [CNT_W-1:0] RST_AUTO_CNT = 6'h10;
    // CMD fields
    localparam int CMD_HOLD_CLR = 0;
    localparam int CMD_TEACH = 1;
    localparam int CMD_SLOT_LSB = 4;
    // STATUS fields
    localparam int STS_BUSY = 0;
    localparam int STS_ERR = 1;
    localparam int STS_TAUGHT_LSB = 4;
    // Area config fields
    localparam int ACF_START_LSB = 0;
    localparam int ACF_END_LSB = 8;
    localparam int ACF_OR = 16;
    localparam int ACF_EN = 17;
    localparam int ACF_TAUGHT = 18;
    // Output select: one byte per output, low bits give the area index
    localparam int SEL_STRIDE = 8;
    localparam int SEL_W = 5;
    // Interrupt events
    localparam int IRQ_W = 3;
    localparam int EV_CHANGE = 0;
    localparam int EV_TEACH_DONE = 1;
    localparam int EV_TEACH_ERR = 2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        BAE_TEACH_IDLE = 1'h0,
        BAE_TEACH_ARMED = 1'h1
    } bae_teach_type;
endpackage : bae_pkg

/* File: tb/bae_plc_model.sv */
// Controller model that latches the area process data each cycle
`timescale 1ns/10ps
module bae_plc_model (
    // Clock
    input wire logic aclk,
    // Process data words from the block
    input wire logic [bae_pkg::WORD_HALF-1:0] area_state_low_word,
    input wire logic [bae_pkg::WORD_HALF-1:0] area_state_high_word,
    // Telegram image, first area in bit 0
    output logic [31:0] area_image
);
    import bae_pkg::*;
    always_ff @(posedge aclk) begin
        area_image <= {area_state_high_word, area_state_low_word};
    end
endmodule : bae_plc_model

/* File: tb/bae_properties.sv */
// Checker of bus and evaluation timing of the beam area block
`timescale 1ns/10ps
module bae_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Measurement and teach
    input wire logic beam_valid,
    input wire logic teach_busy,
    input wire logic [bae_pkg::WORD_HALF-1:0] area_state_low_word,
    input wire logic [bae_pkg::WORD_HALF-1:0] area_state_high_word,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import bae_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_words_moved;
        $changed(area_state_low_word) || $changed(area_state_high_word);
    endsequence
    a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late or early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_words_on_cycle: assert property (s_words_moved |-> $past(beam_valid))
        else $error("area words moved outside a measurement");
    a_teach_ends: assert property (teach_busy && beam_valid |=> !teach_busy)
        else $error("teach not finished at measurement");
endmodule : bae_properties

bind bae_top bae_properties i_props (.aclk(aclk), .aresetn(aresetn), .beam_valid(beam_valid),
    .teach_busy(teach_busy), .area_state_low_word(area_state_low_word),
    .area_state_high_word(area_state_high_word), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* File: tb/testbench.sv */
// Self-checking bench for the beam area evaluation block
`timescale 1ns/10ps
module testbench;
    import bae_pkg::*;
    localparam int NB = 16;
    logic aclk, aresetn = 1'b0, beam_valid = 1'b0, panel_teach_req = 1'b0;
    logic [NB-1:0] beam_interrupted = '0;
    logic [1:0] panel_teach_slot = 2'h0;
    logic [WORD_HALF-1:0] area_state_low_word, area_state_high_word;
    logic [3:0] switch_out;
    logic teach_busy, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, image, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail = 0, checked = 0;

    bae_top #(.BEAM_COUNT(NB)) i_dut (.aclk, .aresetn, .beam_interrupted, .beam_valid,
        .panel_teach_req, .panel_teach_slot, .area_state_low_word, .area_state_high_word,
        .switch_out, .teach_busy, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    bae_plc_model i_plc (.aclk, .area_state_low_word, .area_state_high_word, .area_image(image));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // s_axi_bready is raised late so that the slave must hold its answer
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            n_fail++;
            test_done();
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            n_fail++;
            test_done();
        end
        d = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : axr

    task automatic meas(input logic [NB-1:0] b, input logic [31:0] exp);
        beam_interrupted <= b;
        beam_valid <= 1'b1;
        @(posedge aclk);
        beam_valid <= 1'b0;
        repeat (2) @(posedge aclk);
        chk({area_state_high_word, area_state_low_word}, exp);
        chk(image, exp);
    endtask : meas

    task automatic panel(input logic [1:0] s, input logic [NB-1:0] b, input logic [31:0] exp);
        panel_teach_req <= 1'b1;
        panel_teach_slot <= s;
        @(posedge aclk);
        panel_teach_req <= 1'b0;
        meas(b, exp);
    endtask : panel

    function automatic logic [31:0] cfg(input logic [7:0] s, input logic [7:0] e, input logic o);
        return {14'h0, 1'b1, o, e, s};
    endfunction : cfg

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axw(8'h80, cfg(0, 3, 0));
        axw(8'h84, cfg(2, 5, 1));
        axw(8'hC0, cfg(15, 15, 1));
        axw(8'hFC, cfg(0, 15, 0));
        meas(16'h000F, 32'h0000_0003);
        meas(16'h8007, 32'h0001_0002);
        meas(16'hFFFF, 32'h8001_0003);
        axr(OFS_AREA_HIGH, rd);
        chk(rd, 32'h0000_8001);
        chk(irq, 1'b0);
        axr(8'h40, rd, RESP_SLVERR);
        $display("test areas done");
        axw(OFS_OUT_SEL, 32'h1F10_0100);
        meas(16'h0007, 32'h0000_0002);
        chk(switch_out, 4'h2);
        axw(OFS_CTRL, 32'h0001_0000);
        axw(OFS_CMD, 32'h1);
        meas(16'h0004, 32'h0000_0002);
        meas(16'h0000, 32'h0000_0002);
        axw(OFS_CMD, 32'h1);
        meas(16'h0000, 32'h0);
        axw(OFS_CTRL, 32'h0000_0403);
        meas(16'h0100, 32'h0000_0004);
        axw(OFS_CTRL, 32'h0000_0401);
        meas(16'h00F0, 32'h0000_0002);
        axw(OFS_CTRL, 32'h0);
        $display("test hold and split done");
        axw(OFS_IRQ_MASK, 32'h6);
        axw(OFS_IRQ_STAT, 32'h7);
        axw(OFS_CMD, 32'h32);
        chk(teach_busy, 1'b1);
        meas(16'h0000, 32'h0);
        chk(irq, 1'b1);
        axr(8'h8C, rd);
        chk(rd, 32'h0007_0F00);
        meas(16'hFFFF, 32'h8001_000B);
        axw(OFS_IRQ_STAT, 32'h7);
        chk(irq, 1'b0);
        axw(OFS_CMD, 32'h22);
        meas(16'h0001, 32'h0000_0008);
        axr(OFS_STATUS, rd);
        chk(rd, 32'h0000_0082);
        chk(irq, 1'b1);
        axw(OFS_IRQ_MASK, 32'h0);
        chk(irq, 1'b0);
        axw(OFS_IRQ_STAT, 32'h7);
        $display("test host teach done");
        panel(2'h2, 16'h0007, 32'h0000_000A);
        axr(8'h88, rd);
        chk(rd, 32'h0007_0F03);
        meas(16'h0008, 32'h0000_000E);
        chk(switch_out, 4'h6);
        panel(2'h0, 16'hC000, 32'h0001_000C);
        axr(8'h80, rd);
        chk(rd, 32'h0007_0D00);
        panel(2'h1, 16'h0100, 32'h0000_000D);
        axr(OFS_STATUS, rd);
        chk(rd, 32'h0000_00D2);
        $display("test panel teach done");
        test_done();
    end
endmodule : testbench
